// ---- irs_pkg.sv ----
// What this block does
// R1 - Watchdog overflow in reset mode resets system
// R2 - Watchdog reset holds fixed delay, self-releases
// R3 - Main and internal oscillators stop during reset
// R4 - Clocks halted, resume divided by eight
// R5 - Watchdog cleared in reset, counts afterwards
// R6 - Registers reinitialised, debug control kept
// R7 - RAM kept unless power-on or CPU access
// R8 - Peripherals wait for stabilization after release
// R9 - Undervoltage with select one resets system
// R10 - Undervoltage reset lasts until supply recovers
// R11 - Undervoltage with select zero raises interrupt
// R12 - CPU starts after selected stabilization wait
// R13 - Watchdog runs right after release
// R14 - Watchdog overflow during wait: emergency mode
// R15 - CPU clock source readable by software
// R16 - Each reset source sets its cause flag
// R17 - Cause flags write zero only, set wins
// R18 - Pin reset clears all cause flags
// R19 - Reset delay counted in oscillator cycles
// R20 - Undervoltage input synchronised before use
package irs_pkg;
    // ----------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UVMODE = 8'h04;
    localparam logic [7:0] ADDR_DEBUG  = 8'h08;
    localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
    localparam logic [7:0] ADDR_CLKST  = 8'h10;
    localparam logic [7:0] ADDR_WDT    = 8'h14;
    // ----------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------
    localparam int BIT_WDT_MODE   = 0;
    localparam int BIT_DIV_LO     = 1;
    localparam int BIT_UV_EN      = 0;
    localparam int BIT_UV_SEL     = 1;
    localparam int BIT_F_UV       = 0;
    localparam int BIT_F_CLM      = 1;
    localparam int BIT_F_WDT      = 4;
    localparam int BIT_F_RAM      = 8;
    localparam logic [2:0] DIV_BY8     = 3'h3;
    localparam logic [7:0] DEBUG_RESET = 8'h00;
    // ----------------------------------------------------------
    // Timing
    // ----------------------------------------------------------
    localparam int CLK_NS        = 25;
    localparam int RST_DELAY_NS  = 1000;
    localparam int RST_CYC       = (RST_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int STAB_BASE_NS  = 102400;
    localparam int STAB_BASE_CYC = (STAB_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WDT_OVF_DEF   = 65536;
    localparam int CW            = 20;
    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    typedef enum logic [1:0] {ST_HOLD, ST_UV_HOLD, ST_STAB, ST_RUN} irs_state_t;
    typedef struct packed {
        irs_state_t       state;
        logic [CW-1:0]    cnt;
        logic [CW-1:0]    wdt;
        logic             uv_s1;
        logic             uv_s2;
        logic             uv_prev;
        logic             uv_irq;
        logic             wdt_mode;
        logic [2:0]       div;
        logic             uv_en;
        logic             uv_sel;
        logic [7:0]       debug;
        logic [2:0]       flags;
        logic             ram_lost;
        logic             cpu_int;
        logic [31:0]      rdata;
        logic             slverr;
    } irs_regs_t;
endpackage

// ---- irs_sequencer.sv ----
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module irs_sequencer #(
    parameter int STAB_CYCLES = irs_pkg::STAB_BASE_CYC,
    parameter int WDT_OVF     = irs_pkg::WDT_OVF_DEF
) (
    // Clock and pin reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Reset sources and conditions
    input  wire logic        uv_low_async,
    input  wire logic        clm_reset_req,
    input  wire logic        main_osc_ok,
    input  wire logic [1:0]  stab_sel,
    input  wire logic        cpu_ram_access,
    // Clock, CPU and peripheral control
    output logic             sys_reset_n,
    output logic             main_osc_en,
    output logic             int_osc_en,
    output logic             sub_osc_en,
    output logic             clocks_en,
    output logic [2:0]       cpu_clk_div,
    output logic             cpu_clk_internal,
    output logic             cpu_run,
    output logic             periph_en,
    output logic             ram_retain,
    output logic             uv_det_en,
    output logic             undervoltage_interrupt
);
    // ----------------------------------------------------------
    // State registers
    // ----------------------------------------------------------
    irs_pkg::irs_regs_t r;
    irs_pkg::irs_regs_t next_r;

    logic              in_reset;
    logic              wr;
    logic              setup;
    logic              wdt_ovf;
    logic [irs_pkg::CW-1:0] stab_lim;
    logic [2:0]        set_flags;
    logic              go_hold;
    logic              go_uv;

    localparam logic [irs_pkg::CW-1:0] RST_LAST = irs_pkg::CW'(irs_pkg::RST_CYC - 1);
    localparam logic [irs_pkg::CW-1:0] WDT_LAST = irs_pkg::CW'(WDT_OVF - 1);
    localparam logic [irs_pkg::CW-1:0] ONE      = irs_pkg::CW'(1);

    assign in_reset = (r.state == irs_pkg::ST_HOLD) || (r.state == irs_pkg::ST_UV_HOLD);
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite;
    assign wdt_ovf  = (r.wdt == WDT_LAST);
    // Stabilization wait doubles with each option step
    assign stab_lim = irs_pkg::CW'(STAB_CYCLES) << stab_sel; // R12

    // ----------------------------------------------------------
    // Reset triggers
    // ----------------------------------------------------------
    // Triggers only act while the chip is out of reset
    always_comb begin
        go_uv     = !in_reset && r.uv_en && r.uv_sel && r.uv_s2; // R9 R20
        go_hold   = !in_reset && !go_uv && (clm_reset_req
                    || (r.state == irs_pkg::ST_RUN && wdt_ovf && r.wdt_mode)); // R1
        set_flags = 3'b000;
        if (go_uv) begin
            set_flags[irs_pkg::BIT_F_UV] = 1'b1; // R16
        end
        if (go_hold && clm_reset_req) begin
            set_flags[irs_pkg::BIT_F_CLM] = 1'b1; // R16
        end
        if (go_hold && !clm_reset_req) begin
            set_flags[2] = 1'b1; // R16
        end
    end

    // ----------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.uv_s1   = uv_low_async; // R20
        next_r.uv_s2   = r.uv_s1;
        next_r.uv_prev = r.uv_s2;
        // Interrupt only when the detector is told not to reset
        next_r.uv_irq  = r.uv_en && !r.uv_sel && r.uv_s2 && !r.uv_prev; // R11

        // Register writes take effect in the access phase
        if (wr) begin
            case (paddr)
                irs_pkg::ADDR_CTRL: begin
                    next_r.wdt_mode = pwdata[irs_pkg::BIT_WDT_MODE];
                    next_r.div      = pwdata[irs_pkg::BIT_DIV_LO +: 3];
                end
                irs_pkg::ADDR_UVMODE: begin
                    next_r.uv_en  = pwdata[irs_pkg::BIT_UV_EN];
                    next_r.uv_sel = pwdata[irs_pkg::BIT_UV_SEL];
                end
                irs_pkg::ADDR_DEBUG: begin
                    next_r.debug = pwdata[7:0];
                end
                irs_pkg::ADDR_FLAGS: begin
                    // Writing one leaves a flag as it is
                    next_r.flags[irs_pkg::BIT_F_UV]  = r.flags[irs_pkg::BIT_F_UV]
                                                       & pwdata[irs_pkg::BIT_F_UV]; // R17
                    next_r.flags[irs_pkg::BIT_F_CLM] = r.flags[irs_pkg::BIT_F_CLM]
                                                       & pwdata[irs_pkg::BIT_F_CLM]; // R17
                    next_r.flags[2]                  = r.flags[2]
                                                       & pwdata[irs_pkg::BIT_F_WDT]; // R17
                    next_r.ram_lost = r.ram_lost & pwdata[irs_pkg::BIT_F_RAM];
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over a coincident zero write
        next_r.flags[irs_pkg::BIT_F_UV]  = next_r.flags[irs_pkg::BIT_F_UV]
                                           | set_flags[irs_pkg::BIT_F_UV]; // R17
        next_r.flags[irs_pkg::BIT_F_CLM] = next_r.flags[irs_pkg::BIT_F_CLM]
                                           | set_flags[irs_pkg::BIT_F_CLM]; // R17
        next_r.flags[2]                  = next_r.flags[2]
                                           | set_flags[2]; // R16 R17

        // Sequencer
        case (r.state)
            irs_pkg::ST_HOLD: begin
                next_r.wdt = '0; // R5
                next_r.cnt = r.cnt + ONE;
                if (r.cnt == RST_LAST) begin // R2 R19
                    next_r.state = irs_pkg::ST_STAB;
                    next_r.cnt   = '0;
                end
            end
            irs_pkg::ST_UV_HOLD: begin
                next_r.wdt = '0; // R5
                if (!r.uv_s2) begin // R10
                    next_r.state = irs_pkg::ST_STAB;
                    next_r.cnt   = '0;
                end
            end
            irs_pkg::ST_STAB: begin
                next_r.wdt = r.wdt + ONE; // R13
                // Stabilization only advances on a live main clock
                if (main_osc_ok) begin
                    next_r.cnt = r.cnt + ONE;
                end
                if (wdt_ovf) begin // R14
                    next_r.state   = irs_pkg::ST_RUN;
                    next_r.cpu_int = 1'b1;
                    next_r.wdt     = '0;
                end else if (r.cnt >= stab_lim - ONE) begin // R12
                    next_r.state = irs_pkg::ST_RUN;
                end
            end
            irs_pkg::ST_RUN: begin
                next_r.wdt = wdt_ovf ? '0 : r.wdt + ONE;
                if (wr && paddr == irs_pkg::ADDR_WDT) begin
                    next_r.wdt = '0;
                end
            end
            default: begin
                next_r.state = irs_pkg::ST_HOLD;
            end
        endcase

        // Entry into an internal reset reinitialises the registers
        if (go_uv || go_hold) begin
            next_r.state    = go_uv ? irs_pkg::ST_UV_HOLD : irs_pkg::ST_HOLD;
            next_r.cnt      = '0;
            next_r.wdt      = '0; // R5
            next_r.wdt_mode = 1'b0; // R6
            next_r.div      = irs_pkg::DIV_BY8; // R4
            next_r.cpu_int  = 1'b0;
            // Detector settings survive its own reset
            if (go_hold) begin
                next_r.uv_en  = 1'b0;
                next_r.uv_sel = 1'b0;
            end
            // RAM is trashed only if the CPU was mid-access
            next_r.ram_lost = next_r.ram_lost | cpu_ram_access; // R7
        end

        // Read data captured in the setup phase
        next_r.slverr = 1'b0;
        if (setup) begin
            next_r.rdata = '0;
            case (paddr)
                irs_pkg::ADDR_CTRL: begin
                    next_r.rdata[irs_pkg::BIT_WDT_MODE]     = r.wdt_mode;
                    next_r.rdata[irs_pkg::BIT_DIV_LO +: 3]  = r.div;
                end
                irs_pkg::ADDR_UVMODE: begin
                    next_r.rdata[irs_pkg::BIT_UV_EN]  = r.uv_en;
                    next_r.rdata[irs_pkg::BIT_UV_SEL] = r.uv_sel;
                end
                irs_pkg::ADDR_DEBUG: begin
                    next_r.rdata[7:0] = r.debug;
                end
                irs_pkg::ADDR_FLAGS: begin
                    next_r.rdata[irs_pkg::BIT_F_UV]  = r.flags[irs_pkg::BIT_F_UV];
                    next_r.rdata[irs_pkg::BIT_F_CLM] = r.flags[irs_pkg::BIT_F_CLM];
                    next_r.rdata[irs_pkg::BIT_F_WDT] = r.flags[2];
                    next_r.rdata[irs_pkg::BIT_F_RAM] = r.ram_lost;
                end
                irs_pkg::ADDR_CLKST: begin
                    next_r.rdata[0] = r.cpu_int; // R15
                end
                irs_pkg::ADDR_WDT: begin
                    next_r.rdata[irs_pkg::CW-1:0] = r.wdt;
                end
                default: begin
                    next_r.slverr = 1'b1;
                end
            endcase
        end else begin
            next_r.slverr = r.slverr;
        end
    end

    // ----------------------------------------------------------
    // Register update
    // ----------------------------------------------------------
    // Pin reset clears cause flags; RAM is undefined at power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0; // R18
            r.state    <= irs_pkg::ST_STAB;
            r.div      <= irs_pkg::DIV_BY8;
            r.debug    <= irs_pkg::DEBUG_RESET;
            r.ram_lost <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------
    assign prdata                 = r.rdata;
    assign pready                 = psel && penable;
    assign pslverr                = psel && penable && r.slverr;
    assign sys_reset_n            = !in_reset;
    assign main_osc_en            = !in_reset; // R3
    assign int_osc_en             = !in_reset; // R3
    assign sub_osc_en             = 1'b1; // R3
    assign clocks_en              = (r.state == irs_pkg::ST_RUN); // R4
    assign cpu_run                = (r.state == irs_pkg::ST_RUN); // R12
    assign periph_en              = (r.state == irs_pkg::ST_RUN); // R8
    assign cpu_clk_div            = r.div;
    assign cpu_clk_internal       = r.cpu_int; // R15
    assign ram_retain             = in_reset; // R7
    assign uv_det_en              = r.uv_en && (r.state != irs_pkg::ST_UV_HOLD); // R10
    assign undervoltage_interrupt = r.uv_irq;

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wdt_reset_a: assert property (r.state == irs_pkg::ST_RUN && wdt_ovf && r.wdt_mode
        && !go_uv |=> !sys_reset_n && r.flags[2]) // R1
        else $error("watchdog overflow did not reset");
    hold_len_a: assert property ($rose(r.state == irs_pkg::ST_HOLD) |->
        (r.state == irs_pkg::ST_HOLD) [*8]) // R2
        else $error("watchdog reset hold too short");
    hold_end_a: assert property (r.state == irs_pkg::ST_HOLD && r.cnt == RST_LAST
        |=> r.state == irs_pkg::ST_STAB) // R19
        else $error("watchdog reset did not release");
    osc_stop_a: assert property (!sys_reset_n |-> !main_osc_en && !int_osc_en
        && sub_osc_en && !clocks_en) // R3
        else $error("oscillators running in reset");
    div_init_a: assert property ($rose(r.state == irs_pkg::ST_STAB) && $past(in_reset)
        |-> cpu_clk_div == irs_pkg::DIV_BY8) // R4
        else $error("divider not one eighth");
    wdt_clear_a: assert property (in_reset |=> r.wdt == '0 || !in_reset) // R5
        else $error("watchdog counting in reset");
    debug_keep_a: assert property ((go_hold || go_uv) && !wr |=> $stable(r.debug)) // R6
        else $error("debug control lost");
    uv_hold_a: assert property (r.state == irs_pkg::ST_UV_HOLD && r.uv_s2
        |=> r.state == irs_pkg::ST_UV_HOLD && !uv_det_en) // R10
        else $error("undervoltage reset left early");
    uv_irq_a: assert property (r.uv_en && !r.uv_sel && r.uv_s2 && !r.uv_prev
        |=> undervoltage_interrupt && sys_reset_n) // R11
        else $error("undervoltage interrupt missing");
    emerg_a: assert property (r.state == irs_pkg::ST_STAB && wdt_ovf && !go_uv && !go_hold
        |=> cpu_run && cpu_clk_internal) // R14
        else $error("emergency mode not entered");
    flag_set_a: assert property (go_hold && clm_reset_req
        |=> r.flags[irs_pkg::BIT_F_CLM]) // R17
        else $error("cause flag set lost");

    wdt_rst_c: cover property (go_hold && !clm_reset_req);
    uv_rst_c: cover property (go_uv ##[1:20] r.state == irs_pkg::ST_STAB);
    emerg_c: cover property (r.state == irs_pkg::ST_STAB && wdt_ovf);
    run_c: cover property (r.state == irs_pkg::ST_STAB ##1 r.state == irs_pkg::ST_RUN);
endmodule

// ---- irs_far_side.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------
// Oscillator, supply comparator, clock monitor and CPU stand-in
// ----------------------------------------------------------
module irs_far_side (
    // Clock and oscillator enable from the sequencer
    input  wire logic pclk,
    input  wire logic main_osc_en,
    // Bench knobs
    input  wire logic osc_fail,
    input  wire logic supply_low,
    input  wire logic clm_kick,
    input  wire logic ram_busy,
    // Towards the sequencer
    output logic      main_osc_ok,
    output logic      uv_low_async,
    output logic      clm_reset_req,
    output logic      cpu_ram_access
);
    logic [1:0] start_dly = 2'b00;

    // Crystal needs two cycles to start; a failed one never reports good
    always_ff @(posedge pclk) begin
        start_dly <= main_osc_en ? {start_dly[0], 1'b1} : 2'b00;
    end
    assign main_osc_ok    = start_dly[1] & ~osc_fail;
    // Comparator, monitor and CPU follow the bench directly
    assign uv_low_async   = supply_low;
    assign clm_reset_req  = clm_kick;
    assign cpu_ram_access = ram_busy;
endmodule

// ---- internal_reset_sequencer_bench.sv ----
`timescale 1ns/1ps
module internal_reset_sequencer_bench;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam int OVF = 64;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, uv_low_async, clm_reset_req, main_osc_ok;
    logic [1:0]  stab_sel = 2'h1;
    logic        cpu_ram_access, sys_reset_n, main_osc_en, int_osc_en, sub_osc_en;
    logic        clocks_en, cpu_clk_internal, cpu_run, periph_en, ram_retain;
    logic        uv_det_en, undervoltage_interrupt;
    logic [2:0]  cpu_clk_div;
    logic        osc_fail = 1'b0;
    logic        supply_low = 1'b0;
    logic        clm_kick = 1'b0;
    logic        ram_busy = 1'b0;
    logic [31:0] rdv;
    logic        errv;
    int          bad_count = 0;
    int          samples_checked = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    irs_sequencer #(.STAB_CYCLES(16), .WDT_OVF(OVF)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .uv_low_async(uv_low_async),
        .clm_reset_req(clm_reset_req), .main_osc_ok(main_osc_ok),
        .stab_sel(stab_sel), .cpu_ram_access(cpu_ram_access),
        .sys_reset_n(sys_reset_n), .main_osc_en(main_osc_en),
        .int_osc_en(int_osc_en), .sub_osc_en(sub_osc_en), .clocks_en(clocks_en),
        .cpu_clk_div(cpu_clk_div), .cpu_clk_internal(cpu_clk_internal),
        .cpu_run(cpu_run), .periph_en(periph_en), .ram_retain(ram_retain),
        .uv_det_en(uv_det_en), .undervoltage_interrupt(undervoltage_interrupt));

    irs_far_side far (
        .pclk(pclk), .main_osc_en(main_osc_en), .osc_fail(osc_fail),
        .supply_low(supply_low), .clm_kick(clm_kick), .ram_busy(ram_busy),
        .main_osc_ok(main_osc_ok), .uv_low_async(uv_low_async),
        .clm_reset_req(clm_reset_req), .cpu_ram_access(cpu_ram_access));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Sample a little after the edge so flop outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Wait, bounded, for cpu_run (run=1) or sys_reset_n to reach lvl
    task automatic wait_for(input logic run, input logic lvl, input int lim, output int n);
        n = 0;
        while ((run ? cpu_run : sys_reset_n) !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    task automatic kick_clm(input logic busy, output int n);
        @(posedge pclk);
        clm_kick <= 1'b1;
        ram_busy <= busy;
        @(posedge pclk);
        clm_kick <= 1'b0;
        ram_busy <= 1'b0;
        wait_for(1'b0, 1'b0, 8, n);
        wait_for(1'b0, 1'b1, 100, n);
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_power_on();
        int n;
        tick(20);
        chk("run early", 1'b0, cpu_run);
        wait_for(1'b1, 1'b1, 60, n);
        chk("div code", 3'h3, cpu_clk_div);
        chk("periph on", 1'b1, periph_en);
        rd(irs_pkg::ADDR_WDT);
        chk("wdt count", 1'b1, rdv >= 32 && rdv < OVF);
        rd(irs_pkg::ADDR_CTRL);
        chk("ctrl init", 32'h0000_0006, rdv);
        rd(8'h18);
        chk("unmapped", 1'b1, errv);
    endtask

    task automatic t_wdt_reset();
        int n;
        apb(1'b1, irs_pkg::ADDR_DEBUG, 32'h0000_00A5);
        apb(1'b1, irs_pkg::ADDR_FLAGS, 32'h0000_0000);
        rd(irs_pkg::ADDR_FLAGS);
        chk("flags cleared", 32'h0000_0000, rdv);
        apb(1'b1, irs_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_for(1'b0, 1'b0, 2 * OVF, n);
        chk("main osc", 1'b0, main_osc_en);
        chk("int osc", 1'b0, int_osc_en);
        chk("sub osc", 1'b1, sub_osc_en);
        chk("clocks", 1'b0, clocks_en);
        chk("periph", 1'b0, periph_en);
        chk("ram keep", 1'b1, ram_retain);
        wait_for(1'b0, 1'b1, 100, n);
        chk("hold cycles", irs_pkg::RST_CYC, n);
        rd(irs_pkg::ADDR_WDT);
        chk("wdt runs", 1'b1, rdv > 0 && rdv < 8);
        wait_for(1'b1, 1'b1, 80, n);
        rd(irs_pkg::ADDR_FLAGS);
        chk("wdt flag", 32'h0000_0010, rdv);
        rd(irs_pkg::ADDR_DEBUG);
        chk("debug kept", 32'h0000_00A5, rdv);
        rd(irs_pkg::ADDR_CTRL);
        chk("ctrl reinit", 32'h0000_0006, rdv);
    endtask

    task automatic t_clm();
        int n;
        apb(1'b1, irs_pkg::ADDR_FLAGS, 32'hFFFF_FFFF);
        kick_clm(1'b1, n);
        wait_for(1'b1, 1'b1, 80, n);
        rd(irs_pkg::ADDR_FLAGS);
        chk("clm flags", 32'h0000_0112, rdv);
        // Zero write and clock monitor set land on one access edge
        fork
            apb(1'b1, irs_pkg::ADDR_FLAGS, 32'h0000_0000);
            begin
                repeat (2) @(posedge pclk);
                clm_kick <= 1'b1;
                @(posedge pclk);
                clm_kick <= 1'b0;
            end
        join
        wait_for(1'b0, 1'b0, 8, n);
        wait_for(1'b0, 1'b1, 100, n);
        wait_for(1'b1, 1'b1, 80, n);
        rd(irs_pkg::ADDR_FLAGS);
        chk("set wins", 32'h0000_0002, rdv);
    endtask

    task automatic t_uv_reset();
        int n;
        apb(1'b1, irs_pkg::ADDR_UVMODE, 32'h0000_0003);
        apb(1'b1, irs_pkg::ADDR_FLAGS, 32'h0000_0000);
        @(posedge pclk);
        supply_low <= 1'b1;
        wait_for(1'b0, 1'b0, 8, n);
        chk("uv reset", 1'b0, sys_reset_n);
        tick(60);
        chk("uv hold", 1'b0, sys_reset_n);
        chk("uv det off", 1'b0, uv_det_en);
        @(posedge pclk);
        supply_low <= 1'b0;
        wait_for(1'b0, 1'b1, 8, n);
        chk("uv release", 1'b1, sys_reset_n);
        wait_for(1'b1, 1'b1, 80, n);
        rd(irs_pkg::ADDR_FLAGS);
        chk("uv flag", 32'h0000_0001, rdv);
    endtask

    task automatic t_uv_irq();
        int n;
        apb(1'b1, irs_pkg::ADDR_UVMODE, 32'h0000_0001);
        @(posedge pclk);
        supply_low <= 1'b1;
        n = 0;
        repeat (10) begin
            tick(1);
            if (undervoltage_interrupt === 1'b1) n++;
        end
        chk("irq pulses", 1, n);
        chk("no reset", 1'b1, sys_reset_n);
        @(posedge pclk);
        supply_low <= 1'b0;
        tick(4);
    endtask

    task automatic t_emergency();
        int n;
        @(posedge pclk);
        osc_fail <= 1'b1;
        kick_clm(1'b0, n);
        wait_for(1'b1, 1'b1, OVF + 10, n);
        chk("late start", 1'b1, n >= OVF - 4);
        chk("emerg run", 1'b1, cpu_run);
        chk("on int osc", 1'b1, cpu_clk_internal);
        rd(irs_pkg::ADDR_CLKST);
        chk("clk stat int", 32'h0000_0001, rdv);
        osc_fail <= 1'b0;
        kick_clm(1'b0, n);
        wait_for(1'b1, 1'b1, 80, n);
        rd(irs_pkg::ADDR_CLKST);
        chk("clk stat main", 32'h0000_0000, rdv);
    endtask

    task automatic t_pin_reset();
        int n;
        @(posedge pclk);
        presetn <= 1'b0;
        // Shortest option, so the wait stays well below overflow
        stab_sel <= 2'h0;
        tick(3);
        @(posedge pclk);
        presetn <= 1'b1;
        wait_for(1'b1, 1'b1, 80, n);
        chk("stab wait", 16, n);
        rd(irs_pkg::ADDR_FLAGS);
        chk("pin flags", 32'h0000_0100, rdv);
        rd(irs_pkg::ADDR_DEBUG);
        chk("debug pin", {24'h00_0000, irs_pkg::DEBUG_RESET}, rdv);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_power_on();
        t_wdt_reset();
        t_clm();
        t_uv_reset();
        t_uv_irq();
        t_emergency();
        t_pin_reset();
        results();
    end

    // Whole run needs under 1000 cycles; twenty times that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        results();
    end
endmodule
